// file: hdl/clock_startup_pkg.sv
// Operation
// - Crystal: wake waits 1K or 32K cycles; reset adds 14CK, +4ms, +65ms.
// - RC oscillator runs at nominal 8.0MHz by default before user trim.
// - Programmed divide-by-eight fuse divides the clock by 8; shipped so.
// - Source code 0010 selects the internal RC oscillator; shipped so.
// - Every reset copies the factory trim value into the trim register.
// - Software writes to the trim register retune the RC oscillator.
// - Watchdog oscillator keeps running for watchdog and reset time-out.
// - RC: wake waits 6 cycles; reset adds 14CK, +4ms, +65ms; 10 shipped.
// - Source code 0011 selects the 128kHz internal oscillator.
// - 128kHz: wake waits 6 cycles; reset adds 14CK, +4ms or +65ms.
package clock_startup_pkg;

	// Register indices; byte address is four times the index.
	localparam logic [7:0] TRIM_IDX = 8'h66;
	localparam logic [7:0] STATUS_IDX = 8'h67;
	localparam logic [7:0] CONTROL_IDX = 8'h68;
	localparam int CTRL_SLEEP_BIT = 0;

	// Source select codes and start-up time codes.
	localparam logic [3:0] SEL_RC = 4'h2;
	localparam logic [3:0] SEL_LP = 4'h3;
	localparam logic [2:0] SEL_LF_HI = 3'h2;
	localparam logic [1:0] SUT_BOD = 2'h0;
	localparam logic [1:0] SUT_FAST = 2'h1;
	localparam logic [1:0] SUT_SLOW = 2'h2;
	localparam logic [1:0] SUT_RSVD = 2'h3;

	// Factory fuse values; a fuse bit of 0 means programmed.
	localparam logic [3:0] SEL_RESET = 4'h2;
	localparam logic [1:0] SUT_RESET = 2'h2;
	localparam logic DIV8_PROGRAMMED = 1'b0;

	// Start-up counts in source cycles.
	localparam logic [15:0] RESET_CK = 16'h000e;
	localparam logic [15:0] WAKE_LF_SHORT = 16'h0400;
	localparam logic [15:0] WAKE_LF_LONG = 16'h8000;
	localparam logic [15:0] WAKE_INTERNAL = 16'h0006;
	localparam logic [2:0] DIV8_LAST = 3'h7;

	// Reset delays, timed in watchdog oscillator cycles.
	localparam int WDT_OSC_HZ = 128000;
	localparam int DELAY_SHORT_MS = 4;
	localparam int DELAY_LONG_MS = 65;
	localparam int SHORT_TICKS = DELAY_SHORT_MS * WDT_OSC_HZ / 1000;
	localparam int LONG_TICKS = DELAY_LONG_MS * WDT_OSC_HZ / 1000;

	// Nominal RC frequency reached by the factory trim value.
	localparam int RC_NOMINAL_HZ = 8000000;

	typedef enum logic [2:0] {
		ST_RST_CK,
		ST_RST_MS,
		ST_RUN,
		ST_SLEEP,
		ST_WAKE,
		ST_FAULT
	} phase_t;

	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_RC,
		SRC_LP,
		SRC_LF
	} source_t;

	typedef struct packed {
		logic [3:0] source_sel;
		logic [1:0] startup;
		logic div8;
	} fuse_t;

	typedef struct packed {
		logic [9:0] address;
		logic read;
		logic write;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} avalon_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} avalon_rsp_t;

	typedef struct packed {
		logic rc_en;
		logic lp_en;
		logic lf_en;
		logic wdt_en;
		logic gate;
		logic tick;
		logic [7:0] trim;
	} osc_ctl_t;

endpackage : clock_startup_pkg

// file: hdl/clock_source_startup_select.sv
`timescale 1ns/1ns
`default_nettype none
module clock_source_startup_select
	import clock_startup_pkg::*;
#(
	parameter int SHORT_DELAY_TICKS = SHORT_TICKS,
	parameter int LONG_DELAY_TICKS = LONG_TICKS
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Fuses and factory trim, read during reset.
	input wire fuse_t fuses,
	input wire logic [7:0] factory_trim,
	// One pulse per selected source cycle and per watchdog cycle.
	input wire logic src_tick,
	input wire logic wdt_tick,
	// Wake event from power-down or power-save.
	input wire logic wake_event,
	// Avalon-MM slave.
	input wire avalon_req_t bus_req,
	output avalon_rsp_t bus_rsp,
	// Oscillator controls and gated system clock.
	output osc_ctl_t osc
);

	typedef struct packed {
		phase_t phase;
		fuse_t fuse;
		logic [15:0] count;
		logic [15:0] ms_count;
		logic [2:0] div_cnt;
		logic sleep_req;
		avalon_rsp_t rsp;
		osc_ctl_t osc;
	} state_t;

	state_t st_reg;
	state_t st_next;

	// Maps the source select code onto a source.
	function automatic source_t decode_source(input logic [3:0] sel);
		source_t s;
		s = SRC_NONE;
		if (sel == SEL_RC) begin
			s = SRC_RC;
		end else if (sel == SEL_LP) begin
			s = SRC_LP;
		end else if (sel[3:1] == SEL_LF_HI) begin
			s = SRC_LF;
		end
		return s;
	endfunction : decode_source

	// Cycles to wait after power-down or power-save.
	function automatic logic [15:0] wake_count(input fuse_t f);
		logic [15:0] c;
		c = WAKE_INTERNAL;
		if (decode_source(f.source_sel) == SRC_LF) begin
			c = f.source_sel[0] ? WAKE_LF_LONG : WAKE_LF_SHORT;
		end
		return c;
	endfunction : wake_count

	// Watchdog cycles of extra reset delay for a start-up code.
	function automatic logic [15:0] ms_count(input logic [1:0] startup_time_fuses);
		logic [15:0] c;
		c = 16'h0000;
		if (startup_time_fuses == SUT_FAST) begin
			c = SHORT_DELAY_TICKS[15:0];
		end else if (startup_time_fuses == SUT_SLOW) begin
			c = LONG_DELAY_TICKS[15:0];
		end
		return c;
	endfunction : ms_count

	// True when the bus address hits the given register index.
	function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
		return (a[9:2] == idx) && (a[1:0] == 2'b00);
	endfunction : hit

	source_t src;
	logic req;
	logic [31:0] rd_value;

	assign src = decode_source(st_reg.fuse.source_sel);
	assign req = bus_req.read || bus_req.write;

	// Read data mux; unmapped addresses read as zero.
	always_comb begin
		rd_value = 32'h0000_0000;
		if (hit(bus_req.address, TRIM_IDX)) begin
			rd_value[7:0] = st_reg.osc.trim;
		end else if (hit(bus_req.address, STATUS_IDX)) begin
			rd_value[2:0] = st_reg.phase;
			rd_value[5:4] = src;
			rd_value[8] = (st_reg.phase == ST_FAULT);
			rd_value[9] = (st_reg.fuse.div8 == DIV8_PROGRAMMED);
			rd_value[10] = st_reg.osc.gate;
			rd_value[15:12] = st_reg.fuse.source_sel;
			rd_value[17:16] = st_reg.fuse.startup;
		end else if (hit(bus_req.address, CONTROL_IDX)) begin
			rd_value[CTRL_SLEEP_BIT] = st_reg.sleep_req;
		end
	end

	// Next state: start-up sequencing, clock division and bus access.
	always_comb begin
		st_next = st_reg;
		st_next.osc.tick = 1'b0;
		case (st_reg.phase)
			ST_RST_CK: begin
				// Reserved start-up code or unknown source stops the clock.
				if (src == SRC_NONE || st_reg.fuse.startup == SUT_RSVD) begin
					st_next.phase = ST_FAULT;
				end else if (src_tick) begin
					if (st_reg.count == 16'h0001) begin
						if (st_reg.fuse.startup == SUT_BOD) begin
							st_next.phase = ST_RUN;
						end else begin
							st_next.phase = ST_RST_MS;
						end
						st_next.ms_count = ms_count(st_reg.fuse.startup);
					end else begin
						st_next.count = st_reg.count - 16'h0001;
					end
				end
			end
			ST_RST_MS: begin
				// Millisecond part is timed on the watchdog oscillator.
				if (wdt_tick) begin
					if (st_reg.ms_count <= 16'h0001) begin
						st_next.phase = ST_RUN;
					end else begin
						st_next.ms_count = st_reg.ms_count - 16'h0001;
					end
				end
			end
			ST_RUN: begin
				if (st_reg.sleep_req) begin
					st_next.phase = ST_SLEEP;
					st_next.sleep_req = 1'b0;
				end else if (src_tick) begin
					if (st_reg.fuse.div8 == DIV8_PROGRAMMED) begin
						st_next.div_cnt = st_reg.div_cnt + 3'h1;
						st_next.osc.tick = (st_reg.div_cnt == DIV8_LAST);
					end else begin
						st_next.osc.tick = 1'b1;
					end
				end
			end
			ST_SLEEP: begin
				if (wake_event) begin
					st_next.phase = ST_WAKE;
					st_next.count = wake_count(st_reg.fuse);
				end
			end
			ST_WAKE: begin
				// Count cycles of the restarted source before ungating.
				if (src_tick) begin
					if (st_reg.count == 16'h0001) begin
						st_next.phase = ST_RUN;
						st_next.div_cnt = 3'h0;
					end else begin
						st_next.count = st_reg.count - 16'h0001;
					end
				end
			end
			default: begin
				st_next.phase = ST_FAULT;
			end
		endcase

		// Source oscillator enables follow the source; sleep stops it; watchdog stays on.
		st_next.osc.gate = (st_next.phase == ST_RUN);
		st_next.osc.rc_en = (src == SRC_RC) && (st_next.phase != ST_SLEEP);
		st_next.osc.lp_en = (src == SRC_LP) && (st_next.phase != ST_SLEEP);
		st_next.osc.lf_en = (src == SRC_LF) && (st_next.phase != ST_SLEEP);
		st_next.osc.wdt_en = 1'b1;

		// Bus: one wait cycle, then the access completes.
		if (req && st_reg.rsp.waitrequest) begin
			st_next.rsp.waitrequest = 1'b0;
			st_next.rsp.readdata = bus_req.read ? rd_value : 32'h0000_0000;
		end else begin
			st_next.rsp.waitrequest = 1'b1;
		end
		if (bus_req.write && !st_reg.rsp.waitrequest) begin
			if (hit(bus_req.address, TRIM_IDX) && bus_req.byteenable[0]) begin
				st_next.osc.trim = bus_req.writedata[7:0];
			end else if (hit(bus_req.address, CONTROL_IDX)
				&& bus_req.byteenable[0]) begin
				// A request written as sleep is taken still stands.
				st_next.sleep_req = st_next.sleep_req
					| bus_req.writedata[CTRL_SLEEP_BIT];
			end
		end

		// Reset: latch fuses, load factory trim, restart the delay.
		if (!rst_n) begin
			st_next.phase = ST_RST_CK;
			st_next.fuse = fuses;
			st_next.count = RESET_CK;
			st_next.ms_count = 16'h0000;
			st_next.div_cnt = 3'h0;
			st_next.sleep_req = 1'b0;
			st_next.rsp.readdata = 32'h0000_0000;
			st_next.rsp.waitrequest = 1'b1;
			st_next.osc.trim = factory_trim;
			st_next.osc.gate = 1'b0;
			st_next.osc.tick = 1'b0;
			st_next.osc.rc_en = (decode_source(fuses.source_sel) == SRC_RC);
			st_next.osc.lp_en = (decode_source(fuses.source_sel) == SRC_LP);
			st_next.osc.lf_en = (decode_source(fuses.source_sel) == SRC_LF);
			st_next.osc.wdt_en = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge mclk) begin
		st_reg <= st_next;
	end

	// Outputs straight from the state register.
	assign bus_rsp = st_reg.rsp;
	assign osc = st_reg.osc;

endmodule : clock_source_startup_select
`default_nettype wire

// file: test/startup_checker.sv
`timescale 1ns/1ns
`default_nettype none
module startup_checker
	import clock_startup_pkg::*;
(
	// Watched ports of the block.
	input wire logic mclk,
	input wire logic rst_n,
	input wire fuse_t fuses,
	input wire logic [7:0] factory_trim,
	input wire logic src_tick,
	input wire logic wdt_tick,
	input wire avalon_req_t bus_req,
	input wire avalon_rsp_t bus_rsp,
	input wire osc_ctl_t osc
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// A taken request is answered once, then the slave is busy again.
	sequence taken_s;
		(bus_req.read || bus_req.write) && bus_rsp.waitrequest;
	endsequence
	sequence answer_s;
		!bus_rsp.waitrequest ##1 bus_rsp.waitrequest;
	endsequence
	bus_answer_a: assert property (taken_s |=> answer_s)
		else $error("bus answer wrong");
	wdt_runs_a: assert property (osc.wdt_en)
		else $error("watchdog oscillator off");
	trim_load_a: assert property ($rose(rst_n) |->
		osc.trim == $past(factory_trim)) else $error("trim not loaded");
	trim_write_a: assert property (bus_req.write &&
		!bus_rsp.waitrequest && bus_req.byteenable[0] &&
		bus_req.address == {TRIM_IDX, 2'b00} |=>
		osc.trim == $past(bus_req.writedata[7:0]))
		else $error("trim write lost");
	gate_cause_a: assert property ($rose(osc.gate) |->
		$past(src_tick) || $past(wdt_tick)) else $error("gate opened early");
	rc_select_a: assert property (osc.gate |->
		osc.rc_en == (fuses.source_sel == SEL_RC)) else $error("rc enable");
	lp_select_a: assert property (osc.gate |->
		osc.lp_en == (fuses.source_sel == SEL_LP)) else $error("lp enable");
	div8_rate_a: assert property (osc.tick && !fuses.div8 |=>
		!osc.tick [*7]) else $error("divided tick too fast");
	fault_hold_a: assert property (fuses.startup == SUT_RSVD |->
		!osc.gate) else $error("gate open on reserved code");
endmodule : startup_checker
bind clock_source_startup_select startup_checker startup_checker_i (.mclk,
	.rst_n, .fuses, .factory_trim, .src_tick, .wdt_tick, .bus_req, .bus_rsp,
	.osc);
`default_nettype wire

// file: test/clock_source_startup_select_bench.sv
`timescale 1ns/1ns
`default_nettype none
module clock_source_startup_select_bench
	import clock_startup_pkg::*;
;
	logic mclk = 0, rst_n = 0, src_tick = 0, wdt_tick = 0, wake_event = 0;
	fuse_t fuses = '{SEL_RESET, SUT_RESET, DIV8_PROGRAMMED};
	logic [7:0] factory_trim = 8'h5a;
	avalon_req_t bus_req = '0;
	avalon_rsp_t bus_rsp;
	osc_ctl_t osc;
	int bad_count = 0, comparisons = 0, cycles = 0, n, m;
	logic [31:0] q;
	clock_source_startup_select #(.SHORT_DELAY_TICKS(3),
		.LONG_DELAY_TICKS(5)) clock_source_startup_select_i (.mclk, .rst_n,
		.fuses, .factory_trim, .src_tick, .wdt_tick, .wake_event, .bus_req,
		.bus_rsp, .osc);
	// Clock of 8 ns period.
	always #4 mclk = ~mclk;
	// Source ticks every second cycle, watchdog ticks every third, so a
	// delay counted on the wrong tick shows; a hang ends the run.
	always @(posedge mclk) begin
		src_tick <= ~src_tick;
		wdt_tick <= (cycles % 3 == 0);
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			bad_count++;
			final_report();
		end
	end
	// Compares a result and counts it.
	task automatic check(input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// One bus access, held until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [7:0] idx,
		input logic [31:0] d);
		@(posedge mclk);
		bus_req.address <= {idx, 2'b00};
		bus_req.write <= w;
		bus_req.read <= !w;
		bus_req.byteenable <= 4'hf;
		bus_req.writedata <= d;
		do @(posedge mclk); while (bus_rsp.waitrequest !== 1'b0);
		q = bus_rsp.readdata;
		bus_req.read <= 1'b0;
		bus_req.write <= 1'b0;
	endtask : bus
	// Resets the block with new fuses for six cycles.
	task automatic restart(input logic [3:0] s, input logic [1:0] t,
		input logic d);
		@(posedge mclk);
		rst_n <= 1'b0;
		fuses <= '{s, t, d};
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
	endtask : restart
	// Counts source ticks until the clock gate opens, and watchdog ticks
	// once the reset cycle count has been seen.
	task automatic wait_gate();
		n = 0;
		m = 0;
		@(posedge mclk);
		while (osc.gate !== 1'b1) begin
			if (n >= RESET_CK) begin
				m += int'(wdt_tick);
			end
			n += int'(src_tick);
			@(posedge mclk);
		end
	endtask : wait_gate
	// Counts divided clock ticks over a number of cycles.
	task automatic count_ticks(input int c);
		n = 0;
		repeat (c) begin
			@(posedge mclk);
			n += int'(osc.tick);
		end
	endtask : count_ticks
	// Sleeps, wakes and checks the wake count.
	task automatic sleep_wake(input int e);
		bus(1'b1, CONTROL_IDX, 32'h0000_0001);
		bus(1'b0, STATUS_IDX, 32'h0000_0000);
		check(q[2:0], 32'h0000_0003);
		check(osc.gate, 32'h0000_0000);
		@(posedge mclk);
		wake_event <= 1'b1;
		@(posedge mclk);
		wake_event <= 1'b0;
		wait_gate();
		check(n, e);
	endtask : sleep_wake
	// Prints the counts and the verdict.
	task automatic final_report();
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	// Main sequence of tests.
	initial begin
		restart(SEL_RESET, SUT_RESET, DIV8_PROGRAMMED);
		wait_gate();
		check(m, 32'h0000_0005);
		bus(1'b0, STATUS_IDX, 32'h0000_0000);
		check(q, 32'h0002_2612);
		bus(1'b0, TRIM_IDX, 32'h0000_0000);
		check(q, 32'h0000_005a);
		check(osc.trim, 32'h0000_005a);
		count_ticks(64);
		check(n, 32'h0000_0004);
		bus(1'b1, TRIM_IDX, 32'h0000_0080);
		bus(1'b0, TRIM_IDX, 32'h0000_0000);
		check(q, 32'h0000_0080);
		check(osc.trim, 32'h0000_0080);
		bus(1'b0, 8'hff, 32'h0000_0000);
		check(q, 32'h0000_0000);
		sleep_wake(6);
		restart(SEL_LP, SUT_BOD, 1'b1);
		wait_gate();
		check(n, 32'h0000_000e);
		check(m, 32'h0000_0000);
		check(osc.trim, 32'h0000_005a);
		check(osc.lp_en, 32'h0000_0001);
		count_ticks(16);
		check(n, 32'h0000_0008);
		sleep_wake(6);
		restart(SEL_LP, SUT_FAST, 1'b1);
		wait_gate();
		check(m, 32'h0000_0003);
		restart({SEL_LF_HI, 1'b0}, SUT_BOD, 1'b1);
		wait_gate();
		check(n, 32'h0000_000e);
		check(osc.lf_en, 32'h0000_0001);
		sleep_wake(1024);
		restart({SEL_LF_HI, 1'b1}, SUT_BOD, 1'b1);
		wait_gate();
		check(osc.lf_en, 32'h0000_0001);
		sleep_wake(32768);
		restart(SEL_RC, SUT_RSVD, 1'b1);
		repeat (100) @(posedge mclk);
		bus(1'b0, STATUS_IDX, 32'h0000_0000);
		check(q[2:0], 32'h0000_0005);
		check(osc.gate, 32'h0000_0000);
		final_report();
	end
endmodule : clock_source_startup_select_bench
`default_nettype wire
